// File: emb_pkg.sv
// shared constants and types for the external memory bus interface
package emb_pkg;
	// apb register offsets (byte addresses)
	localparam int         APB_AW     = 8;
	localparam logic [7:0] OFS_WIDTH  = 8'h00;
	localparam logic [7:0] OFS_STATES = 8'h04;
	localparam logic [7:0] OFS_PW_HI  = 8'h08;
	localparam logic [7:0] OFS_PW_LO  = 8'h0c;
	localparam logic [7:0] OFS_BC_UP  = 8'h10;
	localparam logic [7:0] OFS_BC_LO  = 8'h14;
	localparam logic [7:0] OFS_STATUS = 8'h18;
	// reset values after power-on reset
	localparam logic [7:0] RST_WIDTH  = 8'hff;
	localparam logic [7:0] RST_STATES = 8'hff;
	localparam logic [7:0] RST_PW     = 8'hff;
	localparam logic [7:0] RST_BC_UP  = 8'h00;
	localparam logic [7:0] RST_BC_LO  = 8'h3c;
	// field positions
	localparam int BIT_WAIT_EN   = 0;
	localparam int BIT_BURST_EN  = 5;
	localparam int BIT_BURST_LEN = 4;
	localparam int BIT_BURST_CNT = 3;
	// burst limits in words, less one
	localparam logic [2:0] BURST_MAX4 = 3'h3;
	localparam logic [2:0] BURST_MAX8 = 3'h7;
	// access sizes
	localparam logic [1:0] SZ_BYTE = 2'h0;
	localparam logic [1:0] SZ_WORD = 2'h1;
	localparam logic [1:0] SZ_LONG = 2'h2;

	// bus states, gray from ST_IDLE through ST_T1, ST_T2 and ST_WAIT to ST_T3
	typedef enum logic [2:0] {
		ST_IDLE = 3'b000,
		ST_T1   = 3'b001,
		ST_T2   = 3'b011,
		ST_WAIT = 3'b010,
		ST_T3   = 3'b110,
		ST_TB   = 3'b111
	} emb_state_e;

	// request from an internal bus master
	typedef struct packed {
		logic [23:0] addr;
		logic [1:0]  size;
		logic        write;
		logic        ifetch;
		logic [31:0] wdata;
	} emb_req_s;

	// decoded configuration
	typedef struct packed {
		logic [7:0]  width8;
		logic [7:0]  three;
		logic [15:0] pw;
		logic        wait_pin_enable;
		logic        burst_rom_enable;
		logic        burst_cycle_len_sel;
		logic        burst_word_count_sel;
	} emb_cfg_s;

	// external bus pins
	typedef struct packed {
		logic [23:0] addr;
		logic [15:0] dout;
		logic [1:0]  doe;
		logic        rd_n;
		logic        upper_byte_write_strobe_n;
		logic        lower_byte_write_strobe_n;
	} emb_pins_s;
endpackage

// File: emb_sync2.sv
// two flip-flop synchroniser for pin inputs
`timescale 1ns/1ps
module emb_sync2 #(
	parameter int         W   = 1,
	parameter logic [W-1:0] RST = '1
) (
	// clock and reset
	input  wire logic         mclk,
	input  wire logic         rst,
	// level in and out
	input  wire logic [W-1:0] d,
	output logic      [W-1:0] q
);
	logic [W-1:0] s1_r;

	// first stage feeds only the second
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			s1_r <= RST;
			q    <= RST;
		end else begin
			s1_r <= d;
			q    <= s1_r;
		end
	end
endmodule // emb_sync2

// File: emb_regs.sv
// apb register file of the bus controller
`timescale 1ns/1ps
module emb_regs (
	// clock and reset
	input  wire logic                   mclk,
	input  wire logic                   rst,
	// apb slave
	input  wire logic                   psel,
	input  wire logic                   penable,
	input  wire logic                   pwrite,
	input  wire logic [emb_pkg::APB_AW-1:0] paddr,
	input  wire logic [31:0]            pwdata,
	output logic      [31:0]            prdata,
	output logic                        pready,
	output logic                        pslverr,
	// block side
	input  wire logic [7:0]             status,
	output emb_pkg::emb_cfg_s           cfg
);
	import emb_pkg::*;

	logic [7:0] area_width_ctrl_reg_r;
	logic [7:0] area_state_count_reg_r;
	logic [7:0] program_wait_reg_hi_r;
	logic [7:0] program_wait_reg_lo_r;
	logic [7:0] bus_ctrl_reg_upper_r;
	logic [7:0] bus_ctrl_reg_lower_r;
	logic       hit;
	logic [7:0] rd_val;
	logic       wr_ok;

	// address decode
	always_comb begin
		hit    = 1'b1;
		rd_val = 8'h00;
		case (paddr)
			OFS_WIDTH:  rd_val = area_width_ctrl_reg_r;
			OFS_STATES: rd_val = area_state_count_reg_r;
			OFS_PW_HI:  rd_val = program_wait_reg_hi_r;
			OFS_PW_LO:  rd_val = program_wait_reg_lo_r;
			OFS_BC_UP:  rd_val = bus_ctrl_reg_upper_r;
			OFS_BC_LO:  rd_val = bus_ctrl_reg_lower_r;
			OFS_STATUS: rd_val = status;
			default:    hit = 1'b0;
		endcase
	end

	assign wr_ok = psel & penable & pready & pwrite & hit;

	// answer one cycle into the access phase
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			pready  <= 1'b0;
			prdata  <= 32'h0;
			pslverr <= 1'b0;
		end else begin
			pready  <= psel & penable & ~pready;
			prdata  <= {24'h0, rd_val};
			pslverr <= psel & penable & ~pready & ~hit;
		end
	end

	// only power-on reset clears these; manual reset leaves them
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			area_width_ctrl_reg_r  <= RST_WIDTH;
			area_state_count_reg_r <= RST_STATES;
			program_wait_reg_hi_r  <= RST_PW;
			program_wait_reg_lo_r  <= RST_PW;
			bus_ctrl_reg_upper_r   <= RST_BC_UP;
			bus_ctrl_reg_lower_r   <= RST_BC_LO;
		end else if (wr_ok) begin
			case (paddr)
				OFS_WIDTH:  area_width_ctrl_reg_r  <= pwdata[7:0];
				OFS_STATES: area_state_count_reg_r <= pwdata[7:0];
				OFS_PW_HI:  program_wait_reg_hi_r  <= pwdata[7:0];
				OFS_PW_LO:  program_wait_reg_lo_r  <= pwdata[7:0];
				OFS_BC_UP:  bus_ctrl_reg_upper_r   <= pwdata[7:0];
				OFS_BC_LO:  bus_ctrl_reg_lower_r   <= pwdata[7:0];
				default:    ;
			endcase
		end
	end

	// field decode
	assign cfg.width8               = area_width_ctrl_reg_r;
	assign cfg.three                = area_state_count_reg_r;
	assign cfg.pw                   = {program_wait_reg_hi_r, program_wait_reg_lo_r};
	assign cfg.wait_pin_enable      = bus_ctrl_reg_lower_r[BIT_WAIT_EN];
	assign cfg.burst_rom_enable     = bus_ctrl_reg_upper_r[BIT_BURST_EN];
	assign cfg.burst_cycle_len_sel  = bus_ctrl_reg_upper_r[BIT_BURST_LEN];
	assign cfg.burst_word_count_sel = bus_ctrl_reg_upper_r[BIT_BURST_CNT];
endmodule // emb_regs

// File: emb_bus.sv
// external memory bus interface: basic and burst rom cycles
//
// Local design decisions: the register offsets and the APB slave port.
`timescale 1ns/1ps
module emb_bus (
	// clock and resets
	input  wire logic                   mclk,
	input  wire logic                   rst,
	input  wire logic                   man_rst,
	// internal bus master request
	input  wire logic                   req_valid,
	input  emb_pkg::emb_req_s           req,
	output logic                        req_ready,
	// internal bus master answer
	output logic                        rsp_valid,
	output logic      [31:0]            rsp_rdata,
	// apb register port
	input  wire logic                   psel,
	input  wire logic                   penable,
	input  wire logic                   pwrite,
	input  wire logic [emb_pkg::APB_AW-1:0] paddr,
	input  wire logic [31:0]            pwdata,
	output logic      [31:0]            prdata,
	output logic                        pready,
	output logic                        pslverr,
	// external memory pins
	output emb_pkg::emb_pins_s          ext,
	input  wire logic [15:0]            data_in,
	input  wire logic                   wait_n
);
	import emb_pkg::*;

	emb_cfg_s   cfg;
	emb_state_e state_r;
	emb_state_e state_nxt;
	emb_req_s   req_r;
	emb_pins_s  ext_r;
	logic [31:0] wal_r;
	logic [31:0] acc_r;
	logic [1:0]  pc_r;
	logic [1:0]  wc_r;
	logic        tb_r;
	logic        busy_r;
	logic        ready_r;
	logic        rsp_valid_r;
	logic [31:0] rsp_rdata_r;
	logic        bl_live_r;
	logic [23:0] bl_next_r;
	logic [2:0]  bl_left_r;
	logic        wait_n_s;
	logic        accept;
	logic        go;
	logic        done;
	logic        last;
	logic        busy_nxt;
	logic [2:0]  area;
	logic        burst_sp;
	logic        w8;
	logic        three;
	logic [1:0]  pw;
	logic        pin_wait;
	logic [23:0] paddr_c;
	logic        use_burst;
	logic [1:0]  ln;
	logic [7:0]  wbyte;
	logic [15:0] wword;

	// number of pieces less one for a size in a space
	function automatic logic [1:0] last_piece(input logic [1:0] sz, input logic b8);
		if (b8)
			last_piece = (sz == SZ_LONG) ? 2'h3 : (sz == SZ_WORD) ? 2'h1 : 2'h0;
		else
			last_piece = (sz == SZ_LONG) ? 2'h1 : 2'h0;
	endfunction

	// byte lanes in use: bit 1 upper, bit 0 lower
	function automatic logic [1:0] lanes(input logic b8, input logic [1:0] sz,
					     input logic a0);
		if (b8)
			lanes = 2'b10;
		else if (sz == SZ_BYTE)
			lanes = a0 ? 2'b01 : 2'b10;
		else
			lanes = 2'b11;
	endfunction

	// top bit of a byte or word piece in the big-endian longword
	function automatic logic [7:0] piece_top(input logic [1:0] pc, input logic b8);
		piece_top = b8 ? 8'd31 - {3'h0, pc, 3'h0} : 8'd31 - {2'h0, pc, 4'h0};
	endfunction

	// configuration registers over apb
	emb_regs u_regs (
		.mclk    (mclk),
		.rst     (rst),
		.psel    (psel),
		.penable (penable),
		.pwrite  (pwrite),
		.paddr   (paddr),
		.pwdata  (pwdata),
		.prdata  (prdata),
		.pready  (pready),
		.pslverr (pslverr),
		.status  ({3'h0, busy_r, bl_live_r, state_r}),
		.cfg     (cfg)
	);

	// wait request pin into the clock domain
	emb_sync2 #(.W(1), .RST(1'b1)) u_wsync (
		.mclk (mclk),
		.rst  (rst),
		.d    (wait_n),
		.q    (wait_n_s)
	);

	// area decode of the held request
	assign area     = req_r.addr[23:21];
	assign burst_sp = (area == 3'h0) & cfg.burst_rom_enable;
	assign w8       = burst_sp ? 1'b0 : cfg.width8[area];
	assign three    = cfg.three[area];
	assign pw       = cfg.pw[{area, 1'b0} +: 2];
	// one enable for all areas, ignored during manual reset
	assign pin_wait = cfg.wait_pin_enable & ~man_rst & ~wait_n_s;

	// address and data of the current piece
	assign paddr_c = req_r.addr + (w8 ? {22'h0, pc_r} : {21'h0, pc_r, 1'b0});
	assign ln      = lanes(w8, req_r.size, paddr_c[0]);
	assign last    = (pc_r == last_piece(req_r.size, w8));
	assign wbyte   = wal_r[piece_top(pc_r, 1'b1) -: 8];
	assign wword   = wal_r[piece_top(pc_r, 1'b0) -: 16];

	// continue a burst only for fetches of the next word in area 0
	assign use_burst = burst_sp & req_r.ifetch & ~req_r.write & bl_live_r &
			   (paddr_c == bl_next_r) & (bl_left_r != 3'h0);

	assign accept   = req_valid & ready_r;
	assign busy_nxt = accept | (busy_r & ~(done & last));

	// bus state sequencing
	always_comb begin
		state_nxt = state_r;
		go        = 1'b0;
		done      = 1'b0;
		case (state_r)
			ST_IDLE: begin
				if (busy_r) begin
					go        = 1'b1;
					state_nxt = use_burst ? ST_TB : ST_T1;
				end
			end
			ST_T1: state_nxt = ST_T2;
			ST_T2: begin
				// with no program waits the pin is looked at here
				if (!three) begin
					done      = 1'b1;
					state_nxt = ST_IDLE;
				end else if (pw != 2'h0) begin
					state_nxt = ST_WAIT;
				end else if (pin_wait) begin
					state_nxt = ST_WAIT;
				end else begin
					state_nxt = ST_T3;
				end
			end
			ST_WAIT: begin
				if (wc_r != 2'h0)
					state_nxt = ST_WAIT;
				else if (pin_wait)
					state_nxt = ST_WAIT;
				else
					state_nxt = ST_T3;
			end
			ST_T3: begin
				done      = 1'b1;
				state_nxt = ST_IDLE;
			end
			ST_TB: begin
				if (!tb_r) begin
					done      = 1'b1;
					state_nxt = ST_IDLE;
				end
			end
			default: state_nxt = ST_IDLE;
		endcase
	end

	// state, program wait count and burst state count
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			state_r <= ST_IDLE;
			wc_r    <= 2'h0;
			tb_r    <= 1'b0;
		end else begin
			state_r <= state_nxt;
			// a 2-state cycle leaves no count for a later pin wait
			if (state_r == ST_T2 && three && pw != 2'h0)
				wc_r <= pw - 2'h1;
			else if (state_r == ST_T2)
				wc_r <= 2'h0;
			else if (state_r == ST_WAIT && wc_r != 2'h0)
				wc_r <= wc_r - 2'h1;
			if (go)
				tb_r <= cfg.burst_cycle_len_sel;
			else if (state_r == ST_TB)
				tb_r <= 1'b0;
		end
	end

	// request capture, piece stepping and read data assembly
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			req_r  <= '0;
			wal_r  <= 32'h0;
			acc_r  <= 32'h0;
			pc_r   <= 2'h0;
			busy_r <= 1'b0;
		end else begin
			busy_r <= busy_nxt;
			if (accept) begin
				req_r <= req;
				pc_r  <= 2'h0;
				acc_r <= 32'h0;
				case (req.size)
					SZ_BYTE: wal_r <= {req.wdata[7:0], 24'h0};
					SZ_WORD: wal_r <= {req.wdata[15:0], 16'h0};
					default: wal_r <= req.wdata;
				endcase
			end else if (done) begin
				pc_r <= pc_r + 2'h1;
				// unused lane is ignored on reads
				if (!req_r.write) begin
					if (w8)
						acc_r[piece_top(pc_r, 1'b1) -: 8] <= data_in[15:8];
					else if (req_r.size == SZ_BYTE)
						acc_r[31:24] <= ln[0] ? data_in[7:0] : data_in[15:8];
					else
						acc_r[piece_top(pc_r, 1'b0) -: 16] <= data_in;
				end
			end
		end
	end

	// answer to the internal master after the last piece
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			ready_r     <= 1'b0;
			rsp_valid_r <= 1'b0;
			rsp_rdata_r <= 32'h0;
		end else begin
			ready_r     <= ~man_rst & ~busy_nxt;
			rsp_valid_r <= done & last;
			// read data stays until the next read ends
			if (done && last && !req_r.write) begin
				case (req_r.size)
					SZ_BYTE: rsp_rdata_r <= {24'h0, ln[0] ? data_in[7:0] :
						       (w8 ? data_in[15:8] : data_in[15:8])};
					SZ_WORD: rsp_rdata_r <= w8 ? {16'h0, acc_r[31:24], data_in[15:8]}
								   : {16'h0, data_in};
					default: rsp_rdata_r <= w8 ? {acc_r[31:8], data_in[15:8]}
								   : {acc_r[31:16], data_in};
				endcase
			end
		end
	end

	// external pins: drive at piece start, release at its end
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			ext_r.addr                      <= 24'h0;
			ext_r.dout                      <= 16'h0;
			ext_r.doe                       <= 2'b00;
			ext_r.rd_n                      <= 1'b1;
			ext_r.upper_byte_write_strobe_n <= 1'b1;
			ext_r.lower_byte_write_strobe_n <= 1'b1;
		end else if (go) begin
			ext_r.addr <= paddr_c;
			ext_r.rd_n <= req_r.write;
			ext_r.upper_byte_write_strobe_n <= ~(req_r.write & ln[1]);
			// lanes() never names the lower lane in an 8-bit space
			ext_r.lower_byte_write_strobe_n <= ~(req_r.write & ln[0]);
			ext_r.doe  <= req_r.write ? ln : 2'b00;
			if (w8 || req_r.size == SZ_BYTE)
				ext_r.dout <= {wbyte, wbyte};
			else
				ext_r.dout <= wword;
		end else if (done) begin
			ext_r.rd_n                      <= 1'b1;
			ext_r.upper_byte_write_strobe_n <= 1'b1;
			ext_r.lower_byte_write_strobe_n <= 1'b1;
			ext_r.doe                       <= 2'b00;
		end
	end

	// burst window: opened by a full fetch, counted down by bursts
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			bl_live_r <= 1'b0;
			bl_next_r <= 24'h0;
			bl_left_r <= 3'h0;
		end else if (go) begin
			if (state_nxt == ST_TB) begin
				bl_left_r <= bl_left_r - 3'h1;
				bl_next_r <= paddr_c + 24'h2;
			end else if (burst_sp && req_r.ifetch && !req_r.write) begin
				bl_live_r <= 1'b1;
				bl_next_r <= paddr_c + 24'h2;
				bl_left_r <= cfg.burst_word_count_sel ? BURST_MAX8 : BURST_MAX4;
			end else begin
				bl_live_r <= 1'b0;
			end
		end
	end

	// outputs straight from flip-flops
	assign req_ready = ready_r;
	assign rsp_valid = rsp_valid_r;
	assign rsp_rdata = rsp_rdata_r;
	assign ext       = ext_r;
endmodule // emb_bus

// File: emb_bus_assertions.sv
// concurrent checks on the external memory pins and handshakes
`timescale 1ns/1ps
module emb_bus_assertions (
	// clock and reset
	input  wire logic         mclk,
	input  wire logic         rst,
	// handshakes
	input  wire logic         psel,
	input  wire logic         penable,
	input  wire logic         pready,
	input  wire logic         req_ready,
	input  wire logic         rsp_valid,
	// memory pins
	input  emb_pkg::emb_pins_s ext
);
	import emb_pkg::*;
	default clocking cb @(posedge mclk); endclocking
	default disable iff (rst);
	// strobe summaries
	wire up_n = ext.upper_byte_write_strobe_n;
	wire lo_n = ext.lower_byte_write_strobe_n;
	wire wr   = !up_n || !lo_n;
	wire idle = ext.rd_n && !wr;
	sequence s_setup;
		psel && !penable;
	endsequence
	sequence s_access;
		psel && penable;
	endsequence
	chk_read_no_write: assert property (!ext.rd_n |-> !wr)
		else $error("write strobe during read");
	chk_upper_lane: assert property (!up_n |-> ext.doe[1])
		else $error("upper strobe without upper lane");
	chk_lower_lane: assert property (!lo_n |-> ext.doe[0])
		else $error("lower strobe without lower lane");
	chk_read_undriven: assert property (!ext.rd_n |-> ext.doe == 2'b00)
		else $error("lane driven during read");
	chk_lane_eight: assert property (ext.doe == 2'b10 |-> lo_n)
		else $error("lower strobe on upper only write");
	chk_write_hold: assert property (wr && $past(wr) |-> $stable(ext.addr) && $stable(ext.dout))
		else $error("address or data moved in write");
	chk_strobe_min: assert property ($fell(up_n) |=> !up_n)
		else $error("write strobe shorter than two states");
	chk_idle_ready: assert property (req_ready |-> idle)
		else $error("strobe active while ready");
	chk_rsp_released: assert property (rsp_valid |-> idle)
		else $error("strobe active at answer");
	chk_apb_answer: assert property (s_setup ##1 s_access |=> pready)
		else $error("pready late");
endmodule // emb_bus_assertions

bind emb_bus emb_bus_assertions emb_bus_assertions_i (.mclk(mclk), .rst(rst), .psel(psel),
	.penable(penable), .pready(pready), .req_ready(req_ready), .rsp_valid(rsp_valid), .ext(ext));

// File: emb_mem_model.sv
// sram model on both data lanes with a wait request output
`timescale 1ns/1ps
module emb_mem_model (
	// clock
	input  wire logic          mclk,
	// controller pins
	input  emb_pkg::emb_pins_s ext,
	input  wire logic [3:0]    stall,
	// answers to the controller
	output logic      [15:0]   data_in,
	output logic               wait_n
);
	import emb_pkg::*;
	logic [7:0]  mem [256];
	logic [15:0] last_r;
	logic [3:0]  cnt_r;
	logic        act_r;
	wire  [7:0]  a = ext.addr[7:0];
	wire         act = !ext.rd_n || !ext.upper_byte_write_strobe_n
		|| !ext.lower_byte_write_strobe_n;
	// byte pattern equal to its address
	initial begin
		for (int i = 0; i < 256; i++) mem[i] = 8'(i);
		last_r = 16'h0;
		cnt_r = 4'h0;
		act_r = 1'b0;
	end
	// upper lane holds the lower address of a pair
	always @(posedge mclk) begin
		if (!ext.upper_byte_write_strobe_n) mem[a] <= ext.dout[15:8];
		if (!ext.lower_byte_write_strobe_n) mem[a | 8'h01] <= ext.dout[7:0];
		if (!ext.rd_n) last_r <= data_in;
		act_r <= act;
		if (act && !act_r) cnt_r <= stall;
		else if (cnt_r != 4'h0) cnt_r <= cnt_r - 4'h1;
	end
	// released lines show the inverse of the last read
	assign data_in = !ext.rd_n ? {mem[a], mem[a | 8'h01]} : ~last_r;
	assign wait_n = (cnt_r == 4'h0);
endmodule // emb_mem_model

// File: emb_bus_tb.sv
// self-checking bench for the external memory bus interface
`timescale 1ns/1ps
module emb_bus_tb;
	import emb_pkg::*;
	logic        mclk, rst, man_rst, req_valid, req_ready, rsp_valid;
	logic        psel, penable, pwrite, pready, pslverr, wait_n;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata, rsp_rdata;
	logic [15:0] data_in;
	logic [3:0]  stall;
	emb_req_s    req;
	emb_pins_s   ext;
	int          mismatches, total_checks;
	emb_bus emb_bus_i (.mclk(mclk), .rst(rst), .man_rst(man_rst), .req_valid(req_valid),
		.req(req), .req_ready(req_ready), .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .ext(ext), .data_in(data_in),
		.wait_n(wait_n));
	emb_mem_model emb_mem_model_i (.mclk(mclk), .ext(ext), .stall(stall),
		.data_in(data_in), .wait_n(wait_n));
	// free running clock
	always #2.5 mclk = ~mclk;
	// one compared value
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			mismatches++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// apb transfer, answer taken at the pready edge
	task automatic apb(input logic w, input logic [7:0] ad, input logic [31:0] wd,
		output logic [31:0] rd, output logic e);
		@(posedge mclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= ad;
		pwdata <= wd;
		@(posedge mclk);
		penable <= 1'b1;
		do @(posedge mclk); while (pready !== 1'b1);
		rd = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	// register write and compared read
	task automatic wreg(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] x;
		logic e;
		apb(1'b1, a, d, x, e);
	endtask
	task automatic rreg(input logic [7:0] a, input logic [31:0] exp);
		logic [31:0] d;
		logic e;
		apb(1'b0, a, 32'h0, d, e);
		check(d, exp);
	endtask
	// one request, cycles counted from the accepting edge to the answer
	task automatic xfer(input logic [23:0] ad, input logic [1:0] sz, input logic w, f,
		input logic [31:0] wd, output int lat);
		@(posedge mclk);
		req_valid <= 1'b1;
		req <= '{addr: ad, size: sz, write: w, ifetch: f, wdata: wd};
		do @(posedge mclk); while (req_ready !== 1'b1);
		req_valid <= 1'b0;
		lat = 0;
		do begin
			@(posedge mclk);
			lat++;
		end while (rsp_valid !== 1'b1 && lat < 200);
	endtask
	task automatic go(input logic [23:0] ad, input logic [1:0] sz, input logic w, f,
		input logic [31:0] wd, input int el, input logic [31:0] ed);
		int lat;
		xfer(ad, sz, w, f, wd, lat);
		check(lat, el);
		if (!w) check(rsp_rdata, ed);
	endtask
	// power-on register values and an unmapped place
	task automatic t_regs();
		logic [31:0] d;
		logic e;
		rreg(OFS_WIDTH, {24'h0, RST_WIDTH});
		rreg(OFS_STATES, {24'h0, RST_STATES});
		rreg(OFS_PW_LO, {24'h0, RST_PW});
		rreg(OFS_PW_HI, {24'h0, RST_PW});
		rreg(OFS_BC_UP, {24'h0, RST_BC_UP});
		rreg(OFS_BC_LO, {24'h0, RST_BC_LO});
		apb(1'b0, 8'h1c, 32'h0, d, e);
		check({31'h0, e}, 32'h1);
		check(d, 32'h0);
	endtask
	// long word as four byte pieces in an 8-bit 3-state area
	task automatic t_8bit();
		go(24'h200010, SZ_LONG, 1'b1, 1'b0, 32'h11223344, 29, 0);
		check({emb_mem_model_i.mem[16], emb_mem_model_i.mem[17],
			emb_mem_model_i.mem[18], emb_mem_model_i.mem[19]}, 32'h11223344);
		go(24'h200010, SZ_LONG, 1'b0, 1'b0, 0, 29, 32'h11223344);
	endtask
	// 16-bit 2-state area, where the stalling wait pin is not looked at
	task automatic t_16bit();
		wreg(OFS_WIDTH, 32'hf3);
		wreg(OFS_STATES, 32'hfb);
		wreg(OFS_BC_LO, 32'h3d);
		stall <= 4'h4;
		go(24'h400020, SZ_WORD, 1'b1, 1'b0, 32'hbeef, 4, 0);
		go(24'h400023, SZ_BYTE, 1'b1, 1'b0, 32'h5a, 4, 0);
		check({emb_mem_model_i.mem[32], emb_mem_model_i.mem[33],
			emb_mem_model_i.mem[34], emb_mem_model_i.mem[35]}, 32'hbeef225a);
		go(24'h400020, SZ_LONG, 1'b0, 1'b0, 0, 7, 32'hbeef225a);
		go(24'h400022, SZ_BYTE, 1'b0, 1'b0, 0, 4, 32'h22);
	endtask
	// program waits, then pin waits on and off
	task automatic t_pw();
		int lat;
		stall <= 4'h0;
		for (int p = 0; p < 4; p++) begin
			wreg(OFS_PW_LO, 32'h3f | (p << 6));
			go(24'h600040, SZ_WORD, 1'b0, 1'b0, 0, p + 5, 32'h4041);
		end
		stall <= 4'h4;
		xfer(24'h600040, SZ_WORD, 1'b0, 1'b0, 0, lat);
		check(32'(lat > 8), 32'h1);
		wreg(OFS_BC_LO, 32'h3c);
		go(24'h600040, SZ_WORD, 1'b0, 1'b0, 0, 8, 32'h4041);
	endtask
	// manual reset keeps the configuration
	task automatic t_man();
		wreg(OFS_PW_HI, 32'ha5);
		@(posedge mclk);
		man_rst <= 1'b1;
		repeat (3) @(posedge mclk);
		@(negedge mclk);
		check({31'h0, req_ready}, 32'h0);
		@(posedge mclk);
		man_rst <= 1'b0;
		rreg(OFS_PW_HI, 32'ha5);
		rreg(OFS_STATES, 32'hfb);
	endtask
	// fetch burst in area 0, full cycles at the window edges and for data
	task automatic t_burst(input logic [31:0] bc, st, input int full, bl, n);
		logic [23:0] a;
		wreg(OFS_STATES, st);
		wreg(OFS_BC_UP, bc);
		for (int i = 0; i <= n; i++) begin
			a = 24'(8'h80 + 2 * i);
			go(a, SZ_WORD, 1'b0, 1'b1, 0, (i % n == 0) ? full : bl,
				{16'h0, a[7:0], a[7:0] + 8'h1});
		end
		go(a + 24'h2, SZ_WORD, 1'b0, 1'b0, 0, full, {16'h0, a[7:0] + 8'h2, a[7:0] + 8'h3});
	endtask
	// fetches outside area 0 never burst
	task automatic t_area();
		go(24'h400020, SZ_WORD, 1'b0, 1'b1, 0, 4, 32'hbeef);
		go(24'h400022, SZ_WORD, 1'b0, 1'b1, 0, 4, 32'h225a);
	endtask
	// closing verdict
	task automatic conclude();
		$display("checks=%0d mismatches=%0d", total_checks, mismatches);
		if (mismatches == 0 && total_checks > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask
	// main sequence
	initial begin
		{mclk, man_rst, req_valid, psel, penable, pwrite} = '0;
		rst = 1'b1;
		req = '0;
		paddr = 8'h0;
		pwdata = 32'h0;
		stall = 4'h0;
		mismatches = 0;
		total_checks = 0;
		repeat (3) @(posedge mclk);
		rst <= 1'b0;
		t_regs();
		t_8bit();
		t_16bit();
		t_pw();
		t_man();
		t_burst(32'h20, 32'hfa, 4, 3, 4);
		t_area();
		t_burst(32'h38, 32'hfb, 8, 4, 8);
		conclude();
	end
	// watchdog against a hang
	initial begin
		#100000;
		mismatches++;
		conclude();
	end
endmodule // emb_bus_tb
